// *** verilog/tec_pkg.sv ***
// Purpose: constants and types for the 18-bit timer/event counter
// Assumes: classic wishbone slave, 32-bit data, byte-per-word registers
// Notes: prescaler taps come in as strobes from the chip's divider chain
package tec_pkg;
  localparam int CNT_W = 18;
  localparam logic [7:0] OFS_CTL1 = 8'h14;
  localparam logic [7:0] OFS_CTL2 = 8'h15;
  localparam logic [7:0] OFS_STAT = 8'h16;
  localparam logic [7:0] OFS_CMP_LO = 8'h17;
  localparam logic [7:0] OFS_CMP_MID = 8'h18;
  localparam logic [7:0] OFS_CMP_TOP = 8'h19;
  localparam logic [7:0] CTL1_RST = 8'h88;
  localparam logic [7:0] CTL2_RST = 8'h00;
  localparam logic [7:0] CTL2_MASK = 8'hfe;
  localparam logic [7:0] TOP_MASK = 8'h03;
  localparam int BIT_CLR = 7;
  localparam int RUN_HI = 6;
  localparam int RUN_LO = 5;
  localparam int SRC_HI = 4;
  localparam int SRC_LO = 2;
  localparam int MODE_HI = 1;
  localparam int MODE_LO = 0;
  localparam logic [1:0] RUN_STOP = 2'h0;
  localparam logic [1:0] RUN_START = 2'h2;
  localparam logic [2:0] SRC_FC = 3'h1;
  localparam logic [2:0] SRC_DIV7 = 3'h5;
  localparam logic [2:0] SRC_DIV3 = 3'h6;
  localparam logic [2:0] SRC_EXT = 3'h7;
  localparam int FAST_IGNORE = 11;
  typedef enum logic [3:0] {
    TEC_TIMER = 4'h1,
    TEC_EVENT = 4'h2,
    TEC_PWM = 4'h4,
    TEC_RSVD = 4'h8
  } tec_mode_t;
  typedef struct packed {
    logic slow;
    logic sleep;
    logic dv7;
  } tec_pmode_t;
  typedef struct packed {
    logic [7:0] ctl1;
    logic [7:0] ctl2;
    logic [CNT_W-1:0] cmp;
    logic [CNT_W-1:0] cnt;
    logic cmp_hold;
    logic wrap;
    logic ext_q;
    logic irq;
    logic ack;
    logic [7:0] rdat;
  } tec_state_t;
endpackage

// *** verilog/tec_src.sv ***
// Purpose: choose the count tick from tap strobes or the external pin
// Assumes: taps are one-cycle strobes at each divided rate
// Notes: illegal taps for the present power mode give no tick
`timescale 1ns/1ps
module tec_src (
  // selection
  input wire logic [2:0] sel_i,
  input wire tec_pkg::tec_pmode_t pm_i,
  input wire logic [6:0] tap_i,
  input wire logic ext_fall_i,
  // tick out
  output logic tick_o,
  output logic fast_slow_o
);
  always_comb begin
    tick_o = 1'b0;
    fast_slow_o = 1'b0;
    if (sel_i == tec_pkg::SRC_EXT) begin
      tick_o = ext_fall_i;
    end else if ((sel_i == tec_pkg::SRC_DIV7 || sel_i == tec_pkg::SRC_DIV3) &&
                 (pm_i.slow || pm_i.sleep)) begin
      tick_o = 1'b0;
    end else if (sel_i == tec_pkg::SRC_FC && pm_i.sleep) begin
      tick_o = 1'b0;
    end else begin
      tick_o = tap_i[sel_i];
      fast_slow_o = (sel_i == tec_pkg::SRC_FC) && pm_i.slow;
    end
  end
endmodule // tec_src

// *** verilog/tec_top.sv ***
// Purpose: 18-bit timer and event counter with compare match and wrap flag
// Assumes: EXT_COUNT_INPUT already synchronous; wishbone classic, one-wait answer
// Notes: pulse-width mode is decoded but counted like event mode
`timescale 1ns/1ps
module tec_top (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // power mode and prescaler taps
  input wire logic SLOW_I,
  input wire logic SLEEP_I,
  input wire logic DIV_STAGE_OPT_I,
  input wire logic [6:0] TAP_I,
  // external count input
  input wire logic EXT_COUNT_INPUT_I,
  // match event and wrap flag
  output logic MATCH_IRQ_O,
  output logic WRAP_FLAG_O
);
  localparam int CNT_WID = tec_pkg::CNT_W;
  tec_pkg::tec_state_t s_r;
  tec_pkg::tec_state_t s_nxt;
  tec_pkg::tec_pmode_t pm;
  tec_pkg::tec_mode_t mode;
  logic tick;
  logic fast_slow;
  logic ext_fall;
  logic req;
  logic wr;
  logic [CNT_WID-1:0] cnt_inc;
  logic hit;

  function automatic tec_pkg::tec_mode_t dec_mode(input logic [1:0] f);
    case (f)
      2'h0: dec_mode = tec_pkg::TEC_TIMER;
      2'h1: dec_mode = tec_pkg::TEC_EVENT;
      2'h2: dec_mode = tec_pkg::TEC_PWM;
      default: dec_mode = tec_pkg::TEC_RSVD;
    endcase
  endfunction

  assign pm = '{slow: SLOW_I, sleep: SLEEP_I, dv7: DIV_STAGE_OPT_I};
  assign mode = dec_mode(s_r.ctl1[tec_pkg::MODE_HI:tec_pkg::MODE_LO]);
  assign ext_fall = s_r.ext_q & ~EXT_COUNT_INPUT_I;
  assign req = WB_CYC_I & WB_STB_I & ~s_r.ack;
  assign wr = req & WB_WE_I & WB_SEL_I[0];
  assign cnt_inc = s_r.cnt + 18'h00001;

  tec_src u_src (
    .sel_i(s_r.ctl1[tec_pkg::SRC_HI:tec_pkg::SRC_LO]),
    .pm_i(pm),
    .tap_i(TAP_I),
    .ext_fall_i(ext_fall),
    .tick_o(tick),
    .fast_slow_o(fast_slow)
  );

  // in timer mode with the fast clock in slow mode only the upper bits are compared
  always_comb begin
    if (fast_slow && mode == tec_pkg::TEC_TIMER) begin
      hit = cnt_inc[CNT_WID-1:tec_pkg::FAST_IGNORE] ==
            s_r.cmp[CNT_WID-1:tec_pkg::FAST_IGNORE];
    end else begin
      hit = cnt_inc == s_r.cmp;
    end
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.ext_q = EXT_COUNT_INPUT_I;
    s_nxt.irq = 1'b0;
    s_nxt.ack = req;
    s_nxt.ctl1[tec_pkg::BIT_CLR] = 1'b1;
    if (s_r.ctl1[tec_pkg::RUN_HI:tec_pkg::RUN_LO] == tec_pkg::RUN_START &&
        mode != tec_pkg::TEC_RSVD && tick) begin
      if (!s_r.cmp_hold && hit) begin
        s_nxt.cnt = '0;
        s_nxt.irq = 1'b1;
      end else begin
        s_nxt.cnt = cnt_inc;
        if (cnt_inc == '0) begin
          s_nxt.wrap = 1'b1;
        end
      end
    end
    if (req && !WB_WE_I) begin
      case (WB_ADR_I)
        tec_pkg::OFS_CTL1: s_nxt.rdat = s_r.ctl1;
        tec_pkg::OFS_CTL2: s_nxt.rdat = s_r.ctl2;
        tec_pkg::OFS_STAT: s_nxt.rdat = {7'h00, s_r.wrap};
        tec_pkg::OFS_CMP_LO: s_nxt.rdat = s_r.cnt[7:0];
        tec_pkg::OFS_CMP_MID: s_nxt.rdat = s_r.cnt[15:8];
        tec_pkg::OFS_CMP_TOP: s_nxt.rdat = {6'h00, s_r.cnt[17:16]};
        default: s_nxt.rdat = 8'h00;
      endcase
    end
    if (wr) begin
      case (WB_ADR_I)
        tec_pkg::OFS_CTL1: begin
          s_nxt.ctl1 = WB_DAT_I[7:0];
          s_nxt.ctl1[tec_pkg::BIT_CLR] = 1'b1;
          if (!WB_DAT_I[tec_pkg::BIT_CLR]) begin
            s_nxt.cnt = '0;
            s_nxt.wrap = 1'b0;
          end
        end
        tec_pkg::OFS_CTL2: s_nxt.ctl2 = WB_DAT_I[7:0] & tec_pkg::CTL2_MASK;
        tec_pkg::OFS_CMP_LO: begin
          s_nxt.cmp[7:0] = WB_DAT_I[7:0];
          s_nxt.cmp_hold = 1'b1;
        end
        tec_pkg::OFS_CMP_MID: begin
          s_nxt.cmp[15:8] = WB_DAT_I[7:0];
          s_nxt.cmp_hold = 1'b1;
        end
        tec_pkg::OFS_CMP_TOP: begin
          s_nxt.cmp[17:16] = WB_DAT_I[1:0] & tec_pkg::TOP_MASK[1:0];
          s_nxt.cmp_hold = 1'b0;
        end
        default: s_nxt.cmp_hold = s_r.cmp_hold;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s_r <= '{ctl1: tec_pkg::CTL1_RST, ctl2: tec_pkg::CTL2_RST, cmp: '0, cnt: '0,
               cmp_hold: 1'b0, wrap: 1'b0, ext_q: 1'b0, irq: 1'b0, ack: 1'b0,
               rdat: 8'h00};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign WB_ACK_O = s_r.ack;
  assign WB_DAT_O = {24'h000000, s_r.rdat};
  assign MATCH_IRQ_O = s_r.irq;
  assign WRAP_FLAG_O = s_r.wrap;
endmodule // tec_top

// *** test/tec_top_chk.sv ***
// Purpose: port checks for tec_top
// Assumes: classic wishbone, ack one cycle after take, byte lane 0 always on
// Notes: run state shadowed from control writes
`timescale 1ns/1ps
module tec_top_chk (
  // clock and bus
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  // events
  input wire logic MATCH_IRQ_O,
  input wire logic WRAP_FLAG_O
);
  logic tk;
  logic rd;
  logic cw;
  logic run_r;
  assign tk = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign rd = tk && !WB_WE_I;
  assign cw = tk && WB_WE_I && WB_ADR_I == 8'h14;
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) run_r <= 1'b0;
    else if (cw) run_r <= WB_DAT_I[6:5] == 2'h2;
  end
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  property p_ack; tk |=> WB_ACK_O ##1 !WB_ACK_O; endproperty
  a_ack: assert property (p_ack) else $error("ack");
  property p_hi; WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper data");
  property p_top; rd && WB_ADR_I == 8'h19 |=> WB_DAT_O[7:2] == 6'h0; endproperty
  a_top: assert property (p_top) else $error("top byte");
  property p_unm; rd && WB_ADR_I > 8'h19 |=> WB_DAT_O == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped");
  property p_c7; rd && WB_ADR_I == 8'h14 |=> WB_DAT_O[7]; endproperty
  a_c7: assert property (p_c7) else $error("clear bit");
  property p_clr; cw && !WB_DAT_I[7] |=> !WRAP_FLAG_O; endproperty
  a_clr: assert property (p_clr) else $error("wrap clear");
  property p_hold; WRAP_FLAG_O && !(cw && !WB_DAT_I[7]) |=> WRAP_FLAG_O; endproperty
  a_hold: assert property (p_hold) else $error("wrap hold");
  property p_stop; !run_r && !$past(run_r) |-> !MATCH_IRQ_O; endproperty
  a_stop: assert property (p_stop) else $error("irq stopped");
  c_irq: cover property (MATCH_IRQ_O);
  c_clr: cover property (cw && !WB_DAT_I[7]);
  c_top: cover property (rd && WB_ADR_I == 8'h19);
endmodule // tec_top_chk
bind tec_top tec_top_chk i_chk (.*);

// *** test/tec_pulse_src.sv ***
// Purpose: external count pulse source
// Assumes: idles high, falls counted by the block
// Notes: phase length chosen per burst
`timescale 1ns/1ps
module tec_pulse_src (
  // clock and pin
  input wire logic clk_i,
  output logic ext_o
);
  initial ext_o = 1'b1;
  // each level held ph cycles; ph of 8 keeps the rate at clock over 16
  task automatic burst(input int n, input int ph);
    repeat (n) begin
      repeat (ph) @(posedge clk_i);
      ext_o <= 1'b0;
      repeat (ph) @(posedge clk_i);
      ext_o <= 1'b1;
    end
  endtask
endmodule // tec_pulse_src

// *** test/tec_top_bench.sv ***
// Purpose: directed bench for tec_top
// Assumes: ack one cycle after take; taps are one-cycle strobes
// Notes: wrap needs 2^18 ticks, too long here; the checker watches it
`timescale 1ns/1ps
module tec_top_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic slow = 1'b0;
  logic [6:0] tap = 7'h00;
  logic ext;
  logic irq;
  logic wrap;
  int err_total = 0;
  int check_count = 0;
  int irqs = 0;
  initial forever #25 clk = ~clk;
  tec_top i_dut (.REF_CLK_I(clk), .RST_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(cyc),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(wd), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .SLOW_I(slow), .SLEEP_I(1'b0), .DIV_STAGE_OPT_I(1'b0), .TAP_I(tap),
    .EXT_COUNT_INPUT_I(ext), .MATCH_IRQ_O(irq), .WRAP_FLAG_O(wrap));
  tec_pulse_src i_src (.clk_i(clk), .ext_o(ext));
  always @(posedge clk) if (irq === 1'b1) irqs <= irqs + 1;
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wd <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    if (ack !== 1'b1) begin
      err_total++;
      finish_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk($sformatf("reg %h", a), {24'h0, e}, q);
  endtask
  task automatic tick(input int i, input int n);
    repeat (n) begin
      @(posedge clk);
      tap <= 7'h01 << i;
      @(posedge clk);
      tap <= 7'h00;
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h14, 8'h88);
    rd(8'h16, 8'h00);
    wr(8'h15, 8'h00);
    rd(8'h15, 8'h00);
    wr(8'h30, 8'h55);
    rd(8'h30, 8'h00);
    wr(8'h17, 8'h05);
    wr(8'h18, 8'h00);
    wr(8'h19, 8'h00);
    wr(8'h14, 8'hc0);
    tick(0, 12);
    wr(8'h14, 8'h80);
    chk("irqs", 2, irqs);
    rd(8'h17, 8'h02);
    rd(8'h19, 8'h00);
    wr(8'h17, 8'h03);
    wr(8'h14, 8'hc0);
    tick(0, 4);
    wr(8'h14, 8'h80);
    rd(8'h17, 8'h06);
    wr(8'h14, 8'h00);
    rd(8'h17, 8'h00);
    wr(8'h19, 8'h00);
    wr(8'h14, 8'hc0);
    tick(0, 3);
    wr(8'h14, 8'h00);
    chk("irqs", 3, irqs);
    slow <= 1'b1;
    wr(8'h14, 8'hd8);
    tick(6, 4);
    wr(8'h14, 8'h98);
    rd(8'h17, 8'h00);
    slow <= 1'b0;
    wr(8'h17, 8'h02);
    wr(8'h19, 8'h00);
    wr(8'h14, 8'hdd);
    i_src.burst(5, 8);
    wr(8'h14, 8'h9d);
    chk("irqs", 5, irqs);
    rd(8'h17, 8'h01);
    chk("wrap", 32'h0, {31'h0, wrap});
    // compare 0x805: only bits 17:11 count with the fast tap in slow mode
    slow <= 1'b1;
    wr(8'h14, 8'h00);
    wr(8'h17, 8'h05);
    wr(8'h18, 8'h08);
    wr(8'h19, 8'h00);
    wr(8'h14, 8'hc4);
    tick(1, 2048);
    wr(8'h14, 8'h84);
    chk("irqs", 6, irqs);
    rd(8'h18, 8'h00);
    slow <= 1'b0;
    finish_test();
  end
endmodule // tec_top_bench
